// ==== design/afm_defs.vh ====
// Constants for the alert and fault monitor: register indices, field
// positions, reset values, mode codes and timing figures.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef AFM_DEFS_VH
`define AFM_DEFS_VH

// Register indices on the internal register port
`define AFM_REG_CONFIG     8'h00
`define AFM_REG_ADC_CONFIG 8'h01
`define AFM_REG_DIAG       8'h0B
`define AFM_REG_CUR_UNDER  8'h0C
`define AFM_REG_CUR_OVER   8'h0D
`define AFM_REG_BUS_OVER   8'h0E
`define AFM_REG_BUS_UNDER  8'h0F
`define AFM_REG_HEAT_CEIL  8'h10
`define AFM_REG_PWR_CEIL   8'h11

// Threshold reset values
`define AFM_RST_CUR_UNDER  16'h8000
`define AFM_RST_CUR_OVER   16'h7FFF
`define AFM_RST_BUS_OVER   16'h7FFF
`define AFM_RST_BUS_UNDER  16'h0000
`define AFM_RST_HEAT_CEIL  16'hFFFF
`define AFM_RST_PWR_CEIL   16'h7FFF
`define AFM_RST_ZERO16     16'h0000

// Configuration register fields
`define AFM_CFG_RST_BIT    15

// Converter configuration fields and mode codes
`define AFM_MODE_HI        1
`define AFM_MODE_LO        0
`define AFM_MODE_SHUTDOWN  2'h0
`define AFM_MODE_TRIGGER   2'h1
`define AFM_MODE_CONT      2'h2
`define AFM_MODE_CONT_ALT  2'h3
`define AFM_RST_MODE       2'h2

// Diagnostic register bit positions
`define AFM_DG_MEM_OK      0
`define AFM_DG_PWR_OVER    1
`define AFM_DG_BUS_UNDER   2
`define AFM_DG_BUS_OVER    3
`define AFM_DG_CUR_UNDER   4
`define AFM_DG_CUR_OVER    5
`define AFM_DG_HEAT_OVER   6
`define AFM_DG_ARITH_WRAP  7
`define AFM_DG_ENERGY_WRAP 8
`define AFM_DG_CHARGE_WRAP 9
`define AFM_DG_CONV_DONE   10
`define AFM_DG_SETTLED     11
`define AFM_DG_LVL_INVERT  12
`define AFM_DG_AVG_CMP     13
`define AFM_DG_RDY_FAULT   14
`define AFM_DG_HOLD        15

// Limit flag vector order (six flags)
`define AFM_LIM_PWR_OVER   0
`define AFM_LIM_BUS_UNDER  1
`define AFM_LIM_BUS_OVER   2
`define AFM_LIM_CUR_UNDER  3
`define AFM_LIM_CUR_OVER   4
`define AFM_LIM_HEAT_OVER  5

// Timing: settle time in microseconds and clock rate in MHz
`define AFM_SETTLE_US      300
`define AFM_CLK_MHZ        100

`endif

// ==== design/afm_limit_cmp.v ====
// Out-of-range comparator bank for the alert and fault monitor.
// Purely combinational; the caller samples the result on its strobe.
`timescale 1ns/1ps
`include "afm_defs.vh"

module afm_limit_cmp #(
    parameter DATA_W = 16 // Result and threshold width
) (
    input wire [DATA_W-1:0] curVal, // Current result, signed
    input wire [DATA_W-1:0] busVal, // Bus voltage result, positive
    input wire [DATA_W-1:0] heatVal, // Die temperature result, positive
    input wire [DATA_W-1:0] pwrVal, // Power result, signed
    input wire [DATA_W-1:0] curUnderTh, // Current under threshold
    input wire [DATA_W-1:0] curOverTh, // Current over threshold
    input wire [DATA_W-1:0] busOverTh, // Bus over threshold
    input wire [DATA_W-1:0] busUnderTh, // Bus under threshold
    input wire [DATA_W-1:0] heatCeil, // Temperature ceiling
    input wire [DATA_W-1:0] pwrCeil, // Power ceiling
    output wire [5:0] hits // One bit per limit crossed
);

    // Signed greater-than, used for the two signed quantities
    function sgt;
        input [DATA_W-1:0] a;
        input [DATA_W-1:0] b;
        begin
            sgt = $signed(a) > $signed(b);
        end
    endfunction

    // Signed over/under for current and power, unsigned for the rest
    assign hits[`AFM_LIM_CUR_OVER] = sgt(curVal, curOverTh);
    assign hits[`AFM_LIM_CUR_UNDER] = sgt(curUnderTh, curVal);
    assign hits[`AFM_LIM_PWR_OVER] = sgt(pwrVal, pwrCeil);
    // Positive-only quantities: unsigned so a ceiling of all ones never trips
    assign hits[`AFM_LIM_BUS_OVER] = busVal > busOverTh;
    assign hits[`AFM_LIM_BUS_UNDER] = busVal < busUnderTh;
    assign hits[`AFM_LIM_HEAT_OVER] = heatVal > heatCeil;

endmodule // afm_limit_cmp

// ==== design/afm_monitor.v ====
// Alert and fault monitor: thresholds, diagnostic flags, alert pin,
// conversion mode control and register reset.
// Assumes results and event pulses come from logic on clk_sys, and that a
// serial front end drives the register port with one-cycle strobes.
`timescale 1ns/1ps
`include "afm_defs.vh"

module afm_monitor #(
    parameter DATA_W = 16, // Register and result width
    parameter TIME_W = 32, // Elapsed-time counter width
    parameter SETTLE_CYC = `AFM_SETTLE_US * `AFM_CLK_MHZ // Settle cycles
) (
    input wire clk_sys, // System clock, 100 MHz
    input wire arst_n, // Asynchronous reset, active low
    input wire [7:0] regAddr, // Register index
    input wire regWrEn, // Write strobe, one cycle
    input wire [DATA_W-1:0] regWrData, // Write data
    input wire regRdEn, // Read strobe, one cycle
    output reg [DATA_W-1:0] regRdData, // Read data, valid after strobe
    input wire rawValid, // Single conversion result pulse
    input wire [DATA_W-1:0] rawCur, // Single current result
    input wire [DATA_W-1:0] rawBus, // Single bus voltage result
    input wire [DATA_W-1:0] rawHeat, // Single temperature result
    input wire [DATA_W-1:0] rawPwr, // Single power result
    input wire avgValid, // Completed (averaged) conversion pulse
    input wire [DATA_W-1:0] avgCur, // Averaged current
    input wire [DATA_W-1:0] avgBus, // Averaged bus voltage
    input wire [DATA_W-1:0] avgHeat, // Averaged temperature
    input wire [DATA_W-1:0] avgPwr, // Averaged power
    input wire arithWrap, // Arithmetic overflow pulse
    input wire energyWrap, // Energy accumulator overflow pulse
    input wire chargeWrap, // Charge accumulator overflow pulse
    input wire trimMemoryOk, // Trim memory health level
    output reg convRun, // Converter enabled
    output reg convRestart, // Restart conversion pulse
    output reg [TIME_W-1:0] elapsedCnt, // Elapsed cycles in continuous mode
    output reg alertOut, // Alert pin output value, always low
    output reg alertOe // Alert pin pull-down enable
);

    // Settle counter width
    localparam SET_W = 16;
    localparam [SET_W-1:0] SETTLE_LAST = SETTLE_CYC - 1;

    // Threshold registers
    reg [DATA_W-1:0] curUnderTh_q; // Current under threshold
    reg [DATA_W-1:0] curOverTh_q; // Current over threshold
    reg [DATA_W-1:0] busOverTh_q; // Bus over threshold
    reg [DATA_W-1:0] busUnderTh_q; // Bus under threshold
    reg [DATA_W-1:0] heatCeil_q; // Temperature ceiling
    reg [DATA_W-1:0] pwrCeil_q; // Power ceiling

    // Control bits
    reg [1:0] mode_q; // Conversion mode field
    reg faultHold_q; // Fault hold enable
    reg readyToFault_q; // Ready-to-fault enable
    reg avgCompare_q; // Averaged compare enable
    reg levelInvert_q; // Fault level invert

    // Status flags
    reg [5:0] limitFlags_q; // Over/under flags
    reg convDone_q; // Conversion done flag
    reg arithFlag_q; // Arithmetic wrap flag
    reg energyFlag_q; // Energy wrap flag
    reg chargeFlag_q; // Charge wrap flag
    reg alertHeld_q; // Alert state after hold logic
    reg alertHeld_d; // Next alert state
    reg softRst_q; // Soft reset pending
    reg [SET_W-1:0] settleCnt_q; // Settle counter
    reg settled_q; // Results trusted

    // Decoded accesses
    wire wrCfg = regWrEn && (regAddr == `AFM_REG_CONFIG);
    wire wrAdc = regWrEn && (regAddr == `AFM_REG_ADC_CONFIG);
    wire wrDiag = regWrEn && (regAddr == `AFM_REG_DIAG);
    wire rdDiag = regRdEn && (regAddr == `AFM_REG_DIAG);
    wire [1:0] newMode = regWrData[`AFM_MODE_HI:`AFM_MODE_LO];
    wire newIsShut = (newMode == `AFM_MODE_SHUTDOWN);

    // Compare source chosen by the averaged compare enable
    wire cmpStrobe = avgCompare_q ? avgValid : rawValid;
    wire [DATA_W-1:0] selCur = avgCompare_q ? avgCur : rawCur;
    wire [DATA_W-1:0] selBus = avgCompare_q ? avgBus : rawBus;
    wire [DATA_W-1:0] selHeat = avgCompare_q ? avgHeat : rawHeat;
    wire [DATA_W-1:0] selPwr = avgCompare_q ? avgPwr : rawPwr;
    wire [5:0] hits; // Comparator outputs
    wire convActive = convRun; // Results only count while running

    // Comparator bank
    afm_limit_cmp #(
        .DATA_W(DATA_W)
    ) uCmp (
        .curVal(selCur),
        .busVal(selBus),
        .heatVal(selHeat),
        .pwrVal(selPwr),
        .curUnderTh(curUnderTh_q),
        .curOverTh(curOverTh_q),
        .busOverTh(busOverTh_q),
        .busUnderTh(busUnderTh_q),
        .heatCeil(heatCeil_q),
        .pwrCeil(pwrCeil_q),
        .hits(hits)
    );

    // Diagnostic word assembly, shared by readback
    function [DATA_W-1:0] diagWord;
        input [5:0] lim;
        input [3:0] flg; // {charge, energy, arith, done}
        input [3:0] ctl; // {hold, ready, avg, invert}
        input stl;
        input mem;
        begin
            diagWord = {DATA_W{1'b0}};
            diagWord[`AFM_DG_MEM_OK] = mem;
            diagWord[`AFM_DG_PWR_OVER] = lim[`AFM_LIM_PWR_OVER];
            diagWord[`AFM_DG_BUS_UNDER] = lim[`AFM_LIM_BUS_UNDER];
            diagWord[`AFM_DG_BUS_OVER] = lim[`AFM_LIM_BUS_OVER];
            diagWord[`AFM_DG_CUR_UNDER] = lim[`AFM_LIM_CUR_UNDER];
            diagWord[`AFM_DG_CUR_OVER] = lim[`AFM_LIM_CUR_OVER];
            diagWord[`AFM_DG_HEAT_OVER] = lim[`AFM_LIM_HEAT_OVER];
            diagWord[`AFM_DG_ARITH_WRAP] = flg[1];
            diagWord[`AFM_DG_ENERGY_WRAP] = flg[2];
            diagWord[`AFM_DG_CHARGE_WRAP] = flg[3];
            diagWord[`AFM_DG_CONV_DONE] = flg[0];
            diagWord[`AFM_DG_SETTLED] = stl;
            diagWord[`AFM_DG_LVL_INVERT] = ctl[0];
            diagWord[`AFM_DG_AVG_CMP] = ctl[1];
            diagWord[`AFM_DG_RDY_FAULT] = ctl[2];
            diagWord[`AFM_DG_HOLD] = ctl[3];
        end
    endfunction

    // Soft reset request, acted on the next cycle
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            softRst_q <= 1'b0;
        end
        else
        begin
            softRst_q <= wrCfg && regWrData[`AFM_CFG_RST_BIT];
        end
    end

    // Settle timer runs once after power-on only
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            settleCnt_q <= {SET_W{1'b0}};
            settled_q <= 1'b0;
        end
        else if (!settled_q)
        begin
            // Results before this point are not trusted
            if (settleCnt_q == SETTLE_LAST)
            begin
                settled_q <= 1'b1;
            end
            settleCnt_q <= settleCnt_q + 1'b1;
        end
    end

    // Threshold and control registers
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Power-on defaults
            curUnderTh_q <= `AFM_RST_CUR_UNDER;
            curOverTh_q <= `AFM_RST_CUR_OVER;
            busOverTh_q <= `AFM_RST_BUS_OVER;
            busUnderTh_q <= `AFM_RST_BUS_UNDER;
            heatCeil_q <= `AFM_RST_HEAT_CEIL;
            pwrCeil_q <= `AFM_RST_PWR_CEIL;
            faultHold_q <= 1'b0;
            readyToFault_q <= 1'b0;
            avgCompare_q <= 1'b0;
            levelInvert_q <= 1'b0;
        end
        else if (softRst_q)
        begin
            // Same defaults from the reset bit
            curUnderTh_q <= `AFM_RST_CUR_UNDER;
            curOverTh_q <= `AFM_RST_CUR_OVER;
            busOverTh_q <= `AFM_RST_BUS_OVER;
            busUnderTh_q <= `AFM_RST_BUS_UNDER;
            heatCeil_q <= `AFM_RST_HEAT_CEIL;
            pwrCeil_q <= `AFM_RST_PWR_CEIL;
            faultHold_q <= 1'b0;
            readyToFault_q <= 1'b0;
            avgCompare_q <= 1'b0;
            levelInvert_q <= 1'b0;
        end
        else if (regWrEn)
        begin
            // Writes are honoured in every mode, shutdown included
            case (regAddr)
                `AFM_REG_CUR_UNDER: curUnderTh_q <= regWrData;
                `AFM_REG_CUR_OVER: curOverTh_q <= regWrData;
                `AFM_REG_BUS_OVER: busOverTh_q <= regWrData;
                `AFM_REG_BUS_UNDER: busUnderTh_q <= regWrData;
                `AFM_REG_HEAT_CEIL: heatCeil_q <= regWrData;
                `AFM_REG_PWR_CEIL: pwrCeil_q <= regWrData;
                `AFM_REG_DIAG:
                begin
                    faultHold_q <= regWrData[`AFM_DG_HOLD];
                    readyToFault_q <= regWrData[`AFM_DG_RDY_FAULT];
                    avgCompare_q <= regWrData[`AFM_DG_AVG_CMP];
                    levelInvert_q <= regWrData[`AFM_DG_LVL_INVERT];
                end
                default:
                begin
                    // Other indices hold nothing here
                end
            endcase
        end
    end

    // Mode field and converter run control
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_q <= `AFM_RST_MODE;
            convRun <= 1'b1;
            convRestart <= 1'b0;
        end
        else if (softRst_q)
        begin
            mode_q <= `AFM_RST_MODE;
            convRun <= 1'b1;
            convRestart <= 1'b1;
        end
        else if (wrAdc)
        begin
            // Any mode write aborts and restarts, shutdown stops
            mode_q <= newMode;
            convRun <= !newIsShut;
            convRestart <= !newIsShut;
        end
        else
        begin
            convRestart <= 1'b0;
            // A single-shot ends in the shutdown state
            if (avgValid && (mode_q == `AFM_MODE_TRIGGER))
            begin
                convRun <= 1'b0;
            end
        end
    end

    // Elapsed-time count, only meaningful in continuous mode
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            elapsedCnt <= {TIME_W{1'b0}};
        end
        else if (softRst_q || wrAdc)
        begin
            elapsedCnt <= {TIME_W{1'b0}};
        end
        else if (convRun && mode_q[1])
        begin
            elapsedCnt <= elapsedCnt + 1'b1;
        end
    end

    // Limit flags: follow each compare, or accumulate under hold
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            limitFlags_q <= 6'h00;
        end
        else if (softRst_q)
        begin
            limitFlags_q <= 6'h00;
        end
        else if (cmpStrobe && settled_q && convActive)
        begin
            // New hits win over a clear in the same cycle
            if (faultHold_q && !rdDiag)
            begin
                limitFlags_q <= limitFlags_q | hits;
            end
            else
            begin
                limitFlags_q <= hits;
            end
        end
        else if (rdDiag && faultHold_q)
        begin
            limitFlags_q <= 6'h00;
        end
    end

    // Sticky event flags; a set in the clearing cycle wins
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            convDone_q <= 1'b0;
            arithFlag_q <= 1'b0;
            energyFlag_q <= 1'b0;
            chargeFlag_q <= 1'b0;
        end
        else if (softRst_q)
        begin
            convDone_q <= 1'b0;
            arithFlag_q <= 1'b0;
            energyFlag_q <= 1'b0;
            chargeFlag_q <= 1'b0;
        end
        else
        begin
            // Done flag set regardless of the ready-to-fault enable
            if (avgValid && convActive)
            begin
                convDone_q <= 1'b1;
            end
            else if (rdDiag || (wrAdc && !newIsShut))
            begin
                convDone_q <= 1'b0;
            end
            arithFlag_q <= arithWrap | (arithFlag_q & !rdDiag);
            energyFlag_q <= energyWrap | (energyFlag_q & !rdDiag);
            chargeFlag_q <= chargeWrap | (chargeFlag_q & !rdDiag);
        end
    end

    // Alert cause and hold; wrap flags are deliberately left out
    always @*
    begin
        alertHeld_d = (|limitFlags_q) | (readyToFault_q & convDone_q);
        if (faultHold_q && alertHeld_q)
        begin
            alertHeld_d = 1'b1;
        end
        // Read clears the causes; stale flags must not relatch a held alert
        if (rdDiag)
        begin
            alertHeld_d = !faultHold_q && (|limitFlags_q);
        end
        if (softRst_q)
        begin
            alertHeld_d = 1'b0;
        end
    end

    // Alert state and open-drain pin
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            alertHeld_q <= 1'b0;
            alertOut <= 1'b0;
            alertOe <= 1'b0;
        end
        else
        begin
            alertHeld_q <= alertHeld_d;
            alertOut <= 1'b0;
            // Pull low when active, or when idle if inverted
            alertOe <= alertHeld_d ^ levelInvert_q;
        end
    end

    // Register readback, one cycle after the read strobe
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regRdData <= `AFM_RST_ZERO16;
        end
        else if (regRdEn)
        begin
            // Reads work in shutdown as well
            case (regAddr)
                `AFM_REG_CONFIG: regRdData <= `AFM_RST_ZERO16;
                `AFM_REG_ADC_CONFIG: regRdData <= {{(DATA_W-2){1'b0}}, mode_q};
                `AFM_REG_DIAG: regRdData <= diagWord(limitFlags_q,
                    {chargeFlag_q, energyFlag_q, arithFlag_q, convDone_q},
                    {faultHold_q, readyToFault_q, avgCompare_q, levelInvert_q},
                    settled_q, trimMemoryOk);
                `AFM_REG_CUR_UNDER: regRdData <= curUnderTh_q;
                `AFM_REG_CUR_OVER: regRdData <= curOverTh_q;
                `AFM_REG_BUS_OVER: regRdData <= busOverTh_q;
                `AFM_REG_BUS_UNDER: regRdData <= busUnderTh_q;
                `AFM_REG_HEAT_CEIL: regRdData <= heatCeil_q;
                `AFM_REG_PWR_CEIL: regRdData <= pwrCeil_q;
                default: regRdData <= `AFM_RST_ZERO16;
            endcase
        end
    end

endmodule // afm_monitor

// ==== verification/afm_host_pin.sv ====
// Host-side view of the open-drain alert pin and its pull-up.
// Assumes the device gives a pin value and a drive enable.
`timescale 1ns/1ps
module afm_host_pin (
    input wire alertOut, // Pin value from the device
    input wire alertOe, // Pin drive enable
    output wire alertPin // Level the host sees
);
    // Released pin floats to the pull-up level, never keeps a stale value
    assign alertPin = alertOe ? alertOut : 1'b1;
endmodule // afm_host_pin

// ==== verification/afm_monitor_chk.sv ====
// Port checker for the alert and fault monitor.
// Assumes it is bound onto afm_monitor; one clock domain.
`timescale 1ns/1ps
module afm_monitor_chk #(
    parameter DATA_W = 16, // Data width
    parameter SETTLE_CYC = 30000 // Settle cycles
) (
    input wire clk_sys, // Clock
    input wire arst_n, // Reset, active low
    input wire [7:0] regAddr, // Register index
    input wire regWrEn, // Write strobe
    input wire [DATA_W-1:0] regWrData, // Write data
    input wire regRdEn, // Read strobe
    input wire [DATA_W-1:0] regRdData, // Read data
    input wire trimMemoryOk, // Memory health
    input wire convRun, // Converter on
    input wire convRestart, // Restart pulse
    input wire alertOut, // Pin value
    input wire alertOe // Pin enable
);
    reg [31:0] stlCnt_q; // Cycles since reset
    // Saturates so long runs never wrap back to zero
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            stlCnt_q <= 32'h0;
        else if (stlCnt_q < SETTLE_CYC)
            stlCnt_q <= stlCnt_q + 32'h1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    property p_cfgRd;
        regRdEn && regAddr == 8'h00 |=> regRdData == 16'h0000;
    endproperty
    a_cfgRd: assert property (p_cfgRd)
        else $error("config read not zero");
    property p_unmapped;
        regRdEn && regAddr > 8'h11 |=> regRdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_memBit;
        regRdEn && regAddr == 8'h0B |=> regRdData[0] == $past(trimMemoryOk);
    endproperty
    a_memBit: assert property (p_memBit)
        else $error("memory health bit wrong");
    property p_outLow;
        alertOut == 1'b0;
    endproperty
    a_outLow: assert property (p_outLow)
        else $error("alert pin driven high");
    property p_restart;
        regWrEn && regAddr == 8'h01 && regWrData[1:0] != 2'h0 |=> convRestart && convRun;
    endproperty
    a_restart: assert property (p_restart)
        else $error("mode write did not start converter");
    property p_shutStop;
        regWrEn && regAddr == 8'h01 && regWrData[1:0] == 2'h0 |=> !convRun && !convRestart;
    endproperty
    a_shutStop: assert property (p_shutStop)
        else $error("shutdown did not stop converter");
    property p_restartCause;
        convRestart |-> $past(regWrEn) || $past(regWrEn, 2) || $past(regWrEn, 3);
    endproperty
    a_restartCause: assert property (p_restartCause)
        else $error("restart without a write");
    property p_settle;
        stlCnt_q < SETTLE_CYC - 2 |-> !alertOe;
    endproperty
    a_settle: assert property (p_settle)
        else $error("alert before settling");
endmodule // afm_monitor_chk
bind afm_monitor afm_monitor_chk #(.DATA_W(DATA_W), .SETTLE_CYC(SETTLE_CYC)) i_chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .trimMemoryOk(trimMemoryOk), .convRun(convRun), .convRestart(convRestart),
    .alertOut(alertOut), .alertOe(alertOe));

// ==== verification/afm_monitor_tb.sv ====
// Bench for the alert and fault monitor against a reference model.
// Assumes the design, checker and host pin model compile first.
`timescale 1ns/1ps
`include "afm_defs.vh"
module afm_monitor_tb;
    localparam STL = 20; // Short settle span keeps the run brief
    reg clk_sys, arst_n, regWrEn, regRdEn, rawValid, avgValid;
    reg arithWrap, energyWrap, chargeWrap, trimMemoryOk;
    reg [7:0] regAddr;
    reg [15:0] regWrData, vC, vB, vH, vP;
    wire [15:0] regRdData;
    wire [31:0] elapsedCnt;
    wire convRun, convRestart, alertOut, alertOe, alertPin;
    reg [15:0] th [0:5]; // Model thresholds
    reg [5:0] flg; // Model limit flags
    reg [3:0] ctl; // Model {hold, ready, avg, invert}
    reg [2:0] wrp; // Model wrap flags
    reg done, run, trig; // Model converter state
    reg [31:0] seed; // Random state
    integer errTotal, numChecks, i;
    afm_monitor #(.SETTLE_CYC(STL)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .rawValid(rawValid), .rawCur(vC), .rawBus(vB),
        .rawHeat(vH), .rawPwr(vP), .avgValid(avgValid), .avgCur(vC), .avgBus(vB),
        .avgHeat(vH), .avgPwr(vP), .arithWrap(arithWrap), .energyWrap(energyWrap),
        .chargeWrap(chargeWrap), .trimMemoryOk(trimMemoryOk), .convRun(convRun),
        .convRestart(convRestart), .elapsedCnt(elapsedCnt), .alertOut(alertOut),
        .alertOe(alertOe));
    afm_host_pin i_host (.alertOut(alertOut), .alertOe(alertOe), .alertPin(alertPin));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Xorshift source for thresholds and results
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Limit crossings; current and power compare signed
    function automatic logic [5:0] lim(input logic [15:0] c, b, h, p);
        return {h > th[4], $signed(c) > $signed(th[1]), $signed(c) < $signed(th[0]),
            b > th[2], b < th[3], $signed(p) > $signed(th[5])};
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks = numChecks + 1;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            errTotal = errTotal + 1;
        end
    endtask
    task finalReport;
        $display("checks=%0d errors=%0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Model register defaults, shared by both reset kinds
    task mreset;
        th[0] = `AFM_RST_CUR_UNDER;
        th[1] = `AFM_RST_CUR_OVER;
        th[2] = `AFM_RST_BUS_OVER;
        th[3] = `AFM_RST_BUS_UNDER;
        th[4] = `AFM_RST_HEAT_CEIL;
        th[5] = `AFM_RST_PWR_CEIL;
        {ctl, flg, wrp, done, run, trig} = 16'h0002;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(negedge clk_sys);
        regWrEn = 1'b0;
        if (a == `AFM_REG_DIAG) ctl = d[15:12];
        if (a >= `AFM_REG_CUR_UNDER && a <= `AFM_REG_PWR_CEIL) th[a - 8'h0C] = d;
        if (a == `AFM_REG_ADC_CONFIG)
        begin
            run = d[1:0] != 2'h0;
            trig = d[1:0] == `AFM_MODE_TRIGGER;
            if (run) done = 1'b0;
        end
    endtask
    // Host read; a diagnostic read also clears sticky state
    task rd(input logic [7:0] a);
        logic [15:0] e;
        e = 16'h0000;
        if (a == `AFM_REG_DIAG) e = {ctl, 1'b1, done, wrp, flg, trimMemoryOk};
        if (a >= `AFM_REG_CUR_UNDER && a <= `AFM_REG_PWR_CEIL) e = th[a - 8'h0C];
        @(negedge clk_sys);
        {regAddr, regRdEn} = {a, 1'b1};
        @(negedge clk_sys);
        regRdEn = 1'b0;
        chk(regRdData, e);
        if (a == `AFM_REG_DIAG) {done, wrp, flg} = {4'h0, ctl[3] ? 6'h0 : flg};
    endtask
    task pin;
        repeat (2) @(negedge clk_sys);
        chk({15'h0, alertPin}, {15'h0, ~((|flg | (ctl[2] & done)) ^ ctl[0])});
        chk({15'h0, convRun}, {15'h0, run});
    endtask
    // One conversion: m[0] single result, m[1] completed average
    task conv(input logic [1:0] m, input logic [15:0] c, b, h, p);
        @(negedge clk_sys);
        {vC, vB, vH, vP, rawValid, avgValid} = {c, b, h, p, m[0], m[1]};
        @(negedge clk_sys);
        {rawValid, avgValid} = 2'h0;
        if (run && (ctl[1] ? m[1] : m[0])) flg = lim(c, b, h, p) | (ctl[3] ? flg : 6'h0);
        if (run && m[1]) {done, run} = {1'b1, ~trig};
        pin;
    endtask
    initial
    begin
        {regWrEn, regRdEn, rawValid, avgValid, arithWrap, energyWrap, chargeWrap} = 7'h0;
        {regAddr, regWrData, vC, vB, vH, vP, arst_n, trimMemoryOk} = 90'h1;
        {errTotal, numChecks, seed} = {64'h0, 32'h8F513E32};
        mreset;
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        for (i = 12; i < 18; i++) rd(i[7:0]);
        rd(`AFM_REG_CONFIG);
        wr(8'h20, 16'hFFFF);
        rd(8'h20);
        for (i = 12; i < 18; i++) wr(i[7:0], rnd());
        for (i = 12; i < 18; i++) rd(i[7:0]);
        repeat (STL) @(negedge clk_sys);
        for (i = 0; i < 16; i++) conv(2'h3, rnd(), rnd(), rnd(), rnd());
        for (i = 0; i < 3; i++)
        begin
            @(negedge clk_sys);
            {chargeWrap, energyWrap, arithWrap} = 3'h1 << i;
            @(negedge clk_sys);
            {chargeWrap, energyWrap, arithWrap, trimMemoryOk} = {3'h0, i[0]};
            wrp = 3'h1 << i;
            pin;
            rd(`AFM_REG_DIAG);
        end
        trimMemoryOk = 1'b1;
        wr(`AFM_REG_CONFIG, 16'h8000);
        repeat (3) @(negedge clk_sys);
        mreset;
        for (i = 12; i < 18; i++) rd(i[7:0]);
        wr(`AFM_REG_BUS_UNDER, 16'h0100);
        wr(`AFM_REG_DIAG, 16'h9000);
        conv(2'h3, 16'h0, 16'h0, 16'h0, 16'h0);
        conv(2'h3, 16'h0, 16'h0200, 16'h0, 16'h0);
        rd(`AFM_REG_DIAG);
        pin;
        wr(`AFM_REG_DIAG, 16'h4000);
        conv(2'h3, 16'h0, 16'h0200, 16'h0, 16'h0);
        rd(`AFM_REG_DIAG);
        pin;
        wr(`AFM_REG_DIAG, 16'h2000);
        conv(2'h1, 16'h0, 16'h0, 16'h0, 16'h0);
        conv(2'h2, 16'h0, 16'h0, 16'h0, 16'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(`AFM_REG_ADC_CONFIG, {14'h0, i[1:0]});
            chk(elapsedCnt[15:0], 16'h0000);
            @(negedge clk_sys);
            chk(elapsedCnt[15:0], {15'h0, i[1]});
            conv(2'h2, 16'h8000, rnd(), 16'h0, 16'h0);
            rd(`AFM_REG_DIAG);
        end
        finalReport;
    end
    // Hang guard: far beyond the roughly 250 cycles needed
    initial
    begin
        #200000;
        errTotal = errTotal + 1;
        finalReport;
    end
endmodule // afm_monitor_tb
